/* File: irq_enable_pkg.sv */
// Constants of the peripheral interrupt enable bank: offsets, bit
// positions, reset values and the register map seen over APB.
// Assumes a 32-bit APB with byte addresses and word-aligned registers.
package irq_enable_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] enable_one_offset = 8'h00;
	localparam logic [7:0] enable_two_offset = 8'h04;
	localparam logic [7:0] core_control_offset = 8'h08;
	localparam logic [7:0] status_offset = 8'h0C;
	localparam logic [7:0] mask_offset = 8'h10;
	localparam logic [7:0] request_offset = 8'h14;

	// ----------------------------------------------------------------
	// Bit positions, bank one
	// ----------------------------------------------------------------
	localparam int comparator_two_bit = 6;
	localparam int comparator_one_bit = 5;
	localparam int memory_write_done_bit = 4;
	localparam int osc_counter_rollover_bit = 0;

	// ----------------------------------------------------------------
	// Bit positions, bank two
	// ----------------------------------------------------------------
	localparam int oscillator_fail_bit = 7;
	localparam int clock_switch_done_bit = 6;
	localparam int logic_cell_two_bit = 1;
	localparam int logic_cell_one_bit = 0;

	// Core control: global peripheral enable position.
	localparam int global_peripheral_bit = 6;

	// ----------------------------------------------------------------
	// Implemented-bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] enable_one_impl = 8'h71;
	localparam logic [7:0] enable_two_impl = 8'hC3;
	localparam logic [7:0] core_control_impl = 8'h40;
	localparam logic [7:0] enable_reset = 8'h00;
	localparam logic [15:0] status_reset = 16'h0000;
	localparam logic [15:0] mask_reset = 16'h0000;
	localparam logic [31:0] unmapped_read = 32'h0000_0000;

endpackage

/* File: irq_gate.sv */
// Gates one 8-bit bank of raw requests by its enables and the global
// peripheral enable, and catches rising edges of the gated requests.
// Assumes requests are already in the pclk domain.
`timescale 1ns/100ps
module irq_gate (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] raw_req,
	input wire logic [7:0] enable,
	input wire logic global_en,
	output logic [7:0] gated,
	output logic [7:0] rise
);
	import irq_enable_pkg::*;

	logic [7:0] prev_reg;
	logic [7:0] prev_next;

	always_comb begin
		gated = raw_req & enable & {8{global_en}};
		rise = gated & ~prev_reg;
		prev_next = gated;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= enable_reset;
		end else begin
			prev_reg <= prev_next;
		end
	end

endmodule

/* File: peripheral_irq_enable_bank.sv */
// Peripheral interrupt enable bank with APB register access.
// Assumes peripheral requests arrive asynchronously as levels and pass
// a two-flop synchroniser before any gating.
`timescale 1ns/100ps
module peripheral_irq_enable_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] req_bank_one,
	input wire logic [7:0] req_bank_two,
	output logic [7:0] irq_bank_one,
	output logic [7:0] irq_bank_two,
	output logic peripheral_irq,
	output logic irq
);
	import irq_enable_pkg::*;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [15:0] sync1_reg;
	logic [15:0] sync2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= status_reset;
			sync2_reg <= status_reset;
		end else begin
			sync1_reg <= {req_bank_two, req_bank_one};
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] peripheral_irq_enable_one_reg;
	logic [7:0] peripheral_irq_enable_one_next;
	logic [7:0] peripheral_irq_enable_two_reg;
	logic [7:0] peripheral_irq_enable_two_next;
	logic [7:0] core_irq_control_reg;
	logic [7:0] core_irq_control_next;
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [7:0] gated_one;
	logic [7:0] gated_two;
	logic [7:0] rise_one;
	logic [7:0] rise_two;
	logic global_peripheral_irq_en;
	logic setup;
	logic wr;
	logic rd;
	logic mapped;

	assign global_peripheral_irq_en =
		core_irq_control_reg[global_peripheral_bit];

	// ----------------------------------------------------------------
	// Request gating
	// ----------------------------------------------------------------
	// Each implemented enable bit, including bit 0 of bank one, bit 7
	// and bit 0 of bank two, gates its own request; the global enable
	// gates every one of them.
	irq_gate gate_one (
		.pclk(pclk),
		.presetn(presetn),
		.raw_req(sync2_reg[7:0]),
		.enable(peripheral_irq_enable_one_reg),
		.global_en(global_peripheral_irq_en),
		.gated(gated_one),
		.rise(rise_one)
	);

	irq_gate gate_two (
		.pclk(pclk),
		.presetn(presetn),
		.raw_req(sync2_reg[15:8]),
		.enable(peripheral_irq_enable_two_reg),
		.global_en(global_peripheral_irq_en),
		.gated(gated_two),
		.rise(rise_two)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero wait states: the access phase always completes at once.
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;

	always_comb begin
		unique case (paddr)
			enable_one_offset: mapped = 1'b1;
			enable_two_offset: mapped = 1'b1;
			core_control_offset: mapped = 1'b1;
			status_offset: mapped = 1'b1;
			mask_offset: mapped = 1'b1;
			request_offset: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------------------------------
	// Register next values
	// ----------------------------------------------------------------
	// Only byte lane 0 carries the 8-bit registers; the mask register uses
	// lanes 0 and 1, and writes to the status register are ignored.
	always_comb begin
		peripheral_irq_enable_one_next = peripheral_irq_enable_one_reg;
		peripheral_irq_enable_two_next = peripheral_irq_enable_two_reg;
		core_irq_control_next = core_irq_control_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		if (wr && pstrb[0]) begin
			unique case (paddr)
				enable_one_offset: begin
					peripheral_irq_enable_one_next =
						pwdata[7:0] & enable_one_impl;
				end
				enable_two_offset: begin
					peripheral_irq_enable_two_next =
						pwdata[7:0] & enable_two_impl;
				end
				core_control_offset: begin
					core_irq_control_next = pwdata[7:0] & core_control_impl;
				end
				mask_offset: begin
					mask_next[7:0] = pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (wr && pstrb[1] && paddr == mask_offset) begin
			mask_next[15:8] = pwdata[15:8];
		end
		// Read clears the status, but a new edge in the same cycle wins.
		if (rd && paddr == status_offset) begin
			status_next = status_reset;
		end
		status_next = status_next | {rise_two, rise_one};
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Read data is latched in the setup cycle so that it comes from a
	// flip-flop; the status read therefore shows the value before clear.
	always_comb begin
		prdata_next = prdata_reg;
		if (setup && !pwrite) begin
			unique case (paddr)
				enable_one_offset: begin
					prdata_next = {24'h000000, peripheral_irq_enable_one_reg};
				end
				enable_two_offset: begin
					prdata_next = {24'h000000, peripheral_irq_enable_two_reg};
				end
				core_control_offset: begin
					prdata_next = {24'h000000, core_irq_control_reg};
				end
				status_offset: begin
					prdata_next = {16'h0000, status_reg | {rise_two, rise_one}};
				end
				mask_offset: begin
					prdata_next = {16'h0000, mask_reg};
				end
				request_offset: begin
					prdata_next = {16'h0000, gated_two, gated_one};
				end
				default: begin
					prdata_next = unmapped_read;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_irq_enable_one_reg <= enable_reset;
			peripheral_irq_enable_two_reg <= enable_reset;
			core_irq_control_reg <= enable_reset;
			status_reg <= status_reset;
			mask_reg <= mask_reset;
			prdata_reg <= unmapped_read;
		end else begin
			peripheral_irq_enable_one_reg <= peripheral_irq_enable_one_next;
			peripheral_irq_enable_two_reg <= peripheral_irq_enable_two_next;
			core_irq_control_reg <= core_irq_control_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			prdata_reg <= prdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_reg;
	assign irq_bank_one = gated_one;
	assign irq_bank_two = gated_two;
	assign peripheral_irq = |{gated_two, gated_one};
	assign irq = |(status_reg & mask_reg);

endmodule

/* File: peripheral_irq_enable_bank_asserts.sv */
// Checker for the peripheral interrupt enable bank, bound to its top.
// Assumes the register map and zero-wait APB of irq_enable_pkg.
`timescale 1ns/100ps
module irq_bank_checker
import irq_enable_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [7:0] req_bank_one,
	input wire logic [7:0] req_bank_two,
	input wire logic [7:0] irq_bank_one,
	input wire logic [7:0] irq_bank_two,
	input wire logic peripheral_irq,
	input wire logic irq
);
	// ----
	// Shadow of the enables, so gating can be checked from ports alone.
	// ----
	logic [7:0] en_one_reg, en_two_reg;
	logic glob_reg;
	wire wr = psel & penable & pwrite & pstrb[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_one_reg <= 8'h00;
			en_two_reg <= 8'h00;
			glob_reg <= 1'b0;
		end else if (wr) begin
			if (paddr == enable_one_offset)
				en_one_reg <= pwdata[7:0] & enable_one_impl;
			if (paddr == enable_two_offset)
				en_two_reg <= pwdata[7:0] & enable_two_impl;
			if (paddr == core_control_offset)
				glob_reg <= pwdata[global_peripheral_bit];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_gate_one;
		irq_bank_one == ($past(req_bank_one, 2) & en_one_reg & {8{glob_reg}});
	endproperty
	a_gate_one: assert property (p_gate_one) else $error("bank one gating");
	property p_gate_two;
		irq_bank_two == ($past(req_bank_two, 2) & en_two_reg & {8{glob_reg}});
	endproperty
	a_gate_two: assert property (p_gate_two) else $error("bank two gating");
	property p_global;
		!glob_reg |-> !peripheral_irq && {irq_bank_one, irq_bank_two} == 16'h0;
	endproperty
	a_global: assert property (p_global) else $error("global gate");
	property p_or;
		peripheral_irq == (|{irq_bank_one, irq_bank_two});
	endproperty
	a_or: assert property (p_or) else $error("combined request");
	property p_unimpl;
		(irq_bank_one & ~enable_one_impl) == 8'h00 &&
			(irq_bank_two & ~enable_two_impl) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unused bit set");
	property p_rise;
		$rose(req_bank_one[0]) && en_one_reg[0] && glob_reg
			##1 req_bank_one[0] && en_one_reg[0] && glob_reg |=> irq_bank_one[0];
	endproperty
	a_rise: assert property (p_rise) else $error("rollover late");
	property p_unmapped;
		psel && penable && !pwrite && paddr > request_offset
			|-> pslverr && prdata == unmapped_read;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_read_en;
		psel && penable && !pwrite && paddr == enable_two_offset
			|-> prdata == {24'h000000, en_two_reg};
	endproperty
	a_read_en: assert property (p_read_en) else $error("enable readback");
	c_irq: cover property (irq);
	c_periph: cover property (peripheral_irq);
	c_err: cover property (pslverr);
endmodule
bind peripheral_irq_enable_bank irq_bank_checker chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pslverr(pslverr), .req_bank_one(req_bank_one),
	.req_bank_two(req_bank_two), .irq_bank_one(irq_bank_one),
	.irq_bank_two(irq_bank_two), .peripheral_irq(peripheral_irq), .irq(irq));

/* File: peripheral_irq_enable_bank_test.sv */
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes the zero-wait APB and register map of irq_enable_pkg.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module peripheral_irq_enable_bank_test;
import irq_enable_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, irq, pirq, err;
	logic [7:0] paddr = 8'h00, req_one = 8'h00, req_two = 8'h00;
	logic [7:0] irq_one, irq_two;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	int n_fail = 0, tests_run = 0;
	int b1[4] = '{comparator_two_bit, comparator_one_bit,
		memory_write_done_bit, osc_counter_rollover_bit};
	int b2[4] = '{oscillator_fail_bit, clock_switch_done_bit,
		logic_cell_two_bit, logic_cell_one_bit};
	always #2 pclk = ~pclk;
	peripheral_irq_enable_bank dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_bank_one(req_one), .req_bank_two(req_two),
		.irq_bank_one(irq_one), .irq_bank_two(irq_two),
		.peripheral_irq(pirq), .irq(irq));
	// ----
	// Bus access and verdict.
	// ----
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task final_report;
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, enable_one_offset, 32'h0);
		`CHK(rd, 32'h0)
		`CHK({pready, err}, 2'b10)
		apb(1'b1, enable_one_offset, 32'hFFFFFFFF);
		apb(1'b1, enable_two_offset, 32'hFFFFFFFF);
		apb(1'b0, enable_one_offset, 32'h0);
		`CHK(rd[7:0], enable_one_impl)
		apb(1'b0, enable_two_offset, 32'h0);
		`CHK(rd[7:0], enable_two_impl)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({err, rd}, {1'b1, unmapped_read})
		req_one <= 8'hFF;
		req_two <= 8'hFF;
		repeat (4) @(negedge pclk);
		`CHK({irq_one, irq_two, pirq}, 17'h0)
		apb(1'b1, core_control_offset, 32'hFF);
		`CHK(err, 1'b0)
		@(negedge pclk);
		`CHK({irq_one, irq_two, pirq}, {enable_one_impl, enable_two_impl, 1'b1})
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, enable_one_offset, 32'h1 << b1[i]);
			apb(1'b1, enable_two_offset, 32'h1 << b2[i]);
			@(negedge pclk);
			`CHK(irq_one, 8'h1 << b1[i])
			`CHK(irq_two, 8'h1 << b2[i])
		end
		req_one <= 8'h00;
		req_two <= 8'h00;
		repeat (4) @(negedge pclk);
		`CHK(pirq, 1'b0)
		apb(1'b1, mask_offset, 32'h1);
		apb(1'b0, status_offset, 32'h0);
		apb(1'b0, status_offset, 32'h0);
		`CHK(rd, 32'h0)
		req_one <= 8'h01;
		repeat (4) @(negedge pclk);
		`CHK(irq, 1'b1)
		apb(1'b1, mask_offset, 32'h0);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b0, status_offset, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b1, core_control_offset, 32'h0);
		req_two <= 8'h01;
		repeat (4) @(negedge pclk);
		`CHK(irq_two, 8'h00)
		apb(1'b0, status_offset, 32'h0);
		`CHK(rd, 32'h0)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, enable_two_offset, 32'h0);
		`CHK(rd, 32'h0)
		final_report;
	end
endmodule
